// File: include/tape_seq_pkg.sv
package tape_seq_pkg;

   // Stored instruction codes, two bits each.
   typedef enum logic [1:0] {
      INSTR_REWIND  = 2'h0,
      INSTR_FORWARD = 2'h3,
      INSTR_WRITE   = 2'h1,
      INSTR_REVERSE = 2'h2
   } instr_t;

   // Mode selector positions.
   typedef enum logic [1:0] {
      MODE_LOAD = 2'h0,
      MODE_STEP = 2'h1,
      MODE_RUN  = 2'h2
   } mode_t;

   // Tape control selector positions.
   typedef enum logic [1:0] {
      TAPE_IDLE   = 2'h0,
      TAPE_UNLOAD = 2'h1,
      TAPE_REWIND = 2'h2
   } tape_sel_t;

   localparam int unsigned ADDR_W       = 3;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned PULSE_US     = 1;
   localparam int unsigned PULSE_CYC    = PULSE_US * CLK_MHZ;
   localparam int unsigned CNT_W        = 8;

   localparam logic [31:0] APB_OFS_CTRL   = 32'h0000_0000;
   localparam logic [31:0] APB_OFS_STATUS = 32'h0000_0004;
   localparam int unsigned CTRL_MC_BIT    = 0;
   localparam int unsigned CTRL_IT_BIT    = 1;
   localparam int unsigned CTRL_SS_BIT    = 2;
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

   // Motion commands to the transport, travel together.
   typedef struct packed {
      logic fwd;
      logic rev;
      logic wr;
      logic rew;
   } motion_t;

   // Timing-chain pulses from the outside chain.
   typedef struct packed {
      logic t1;
      logic t2;
      logic t3;
   } timing_t;

endpackage : tape_seq_pkg

// File: hw/tape_seq.sv
`timescale 1ns/1ps
// How it works
// - Internal-test off: simulated write reply held clear, transport reply used.
// - Reverse direction with go pulse clears simulated write reply.
// - Direction flag set means forward, clear means reverse.
// - Without backspace, memory forward sets direction, reverse clears it.
// - Backspace blocks set/clear; backspace with timing pulse 2 toggles direction.
// - End of operation advances address unless at breakpoint or backspacing.
// - Start pressed in load mode advances address.
// - Master clear, or breakpoint with end-of-op and backspace, zeroes address.
// - Breakpoint sets when address matches selector, on end-of-op or start.
// - Breakpoint clears on master clear or pulse 1; held clear in load.
// - Unload or rewind selection sends one 1 us active-low pulse.
// - Rewind instruction with go pulse and no write-terminate sends rewind.
// - Write-terminate sets at pulse 3 when reverse and write reply active.
// - Write-terminate forces forward motion to make a record gap.
// - Busy pulse clears write-terminate.
// - Write needs forward, write instruction, go and write enable.
// - Forward line is write-terminate OR direction flag.
// - Start outside load sets repeat and go; step clears repeat 1 us later.
// - Run keeps repeat until mode goes to step or master clear.
// - No motion instruction runs until go is set.
// - Reverse only without write-terminate and without rewind command.
// - Write-terminate falling sets go through a 1 us pulse.
// - Instructions are two-bit codes: rewind, forward, write, reverse.
// - Three-bit program address counts 000 through 111.
module tape_seq
   import tape_seq_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              start_btn_i,
   input  wire mode_t             mode_i,
   input  wire tape_sel_t         tape_sel_i,
   input  wire logic [ADDR_W-1:0] bp_sel_i,
   input  wire instr_t            instr_i,
   input  wire logic              backspace_i,
   input  wire timing_t           timing_i,
   input  wire logic              record_mode_i,
   input  wire logic              load_point_i,
   input  wire logic              end_of_tape_i,
   input  wire logic              rec_end_i,
   input  wire logic              busy_pulse_i,
   input  wire logic              go_clear_i,
   input  wire logic              set_enable_i,
   input  wire logic              write_reply_i,
   input  wire logic              write_ring_i,
   output logic [ADDR_W-1:0]      prog_addr_o,
   output motion_t                motion_o,
   output logic                   rewind_n_o,
   output logic                   rewind_unload_n_o,
   output logic                   go_o,
   output logic                   write_reply_o
);

   // Software-controlled bits and the bus answer.
   logic [31:0]       ctrl_r, ctrl_nxt;
   logic [31:0]       prdata_r, prdata_nxt;
   logic              pready_r, pready_nxt;
   logic              pslverr_r, pslverr_nxt;
   // Pushbutton synchroniser and selector history.
   logic [2:0]        start_sync_r, start_sync_nxt;
   tape_sel_t         tape_prev_r, tape_prev_nxt;
   // Sequencer flags.
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic              dir_r, dir_nxt;
   logic              bp_r, bp_nxt;
   logic              wt_r, wt_nxt;
   logic              go_r, go_nxt;
   logic              rep_r, rep_nxt;
   logic              iwr_r, iwr_nxt;
   logic              go_d_r, go_d_nxt;
   logic [CNT_W-1:0]  step_cnt_r, step_cnt_nxt;
   logic [CNT_W-1:0]  gojog_cnt_r, gojog_cnt_nxt;
   logic [CNT_W-1:0]  rew_cnt_r, rew_cnt_nxt;
   logic [CNT_W-1:0]  unl_cnt_r, unl_cnt_nxt;
   motion_t           motion_r, motion_nxt;
   logic              wr_reply_r, wr_reply_nxt;
   // Active-low operator lines get their own flops so no gate sits before the pin.
   logic              rew_n_r, rew_n_nxt;
   logic              unl_n_r, unl_n_nxt;

   logic master_clear;
   logic int_test;
   logic ss_test;
   logic start_pulse;
   logic end_op;
   logic go_pulse;
   logic reply;
   logic rew_cmd;

   // Single-cycle APB answer with zero wait states.
   always_comb begin
      ctrl_nxt    = ctrl_r;
      prdata_nxt  = prdata_r;
      pready_nxt  = 1'b0;
      pslverr_nxt = 1'b0;
      if (psel_i && !penable_i) begin
         pready_nxt = 1'b1;
         if (pwrite_i) begin
            if (paddr_i == APB_OFS_CTRL) begin
               ctrl_nxt = {29'h0, pwdata_i[2:0]};
            end else if (paddr_i != APB_OFS_STATUS) begin
               pslverr_nxt = 1'b1;
            end
         end else begin
            case (paddr_i)
               APB_OFS_CTRL:   prdata_nxt = ctrl_r;
               APB_OFS_STATUS: prdata_nxt = {22'h0, addr_r, wt_r, bp_r, rep_r,
                                             go_r, dir_r, reply, 1'b0};
               default: begin
                  prdata_nxt  = 32'h0;
                  pslverr_nxt = 1'b1;
               end
            endcase
         end
      end
   end

   // Decoded control bits.
   assign master_clear = ctrl_r[CTRL_MC_BIT];
   assign int_test     = ctrl_r[CTRL_IT_BIT];
   assign ss_test      = ctrl_r[CTRL_SS_BIT];

   // Start is a raw pushbutton; the first stage only feeds the second.
   assign start_pulse = start_sync_r[1] & ~start_sync_r[2];
   assign end_op = record_mode_i ? rec_end_i : (load_point_i | end_of_tape_i);
   // The go pulse is the rising edge of the go flag.
   assign go_pulse = go_r & ~go_d_r;
   assign reply    = int_test ? iwr_r : write_reply_i;
   assign rew_cmd  = (instr_i == INSTR_REWIND) && go_pulse && !wt_r;

   // Next-state logic for the sequencer flags.
   always_comb begin
      start_sync_nxt = {start_sync_r[1:0], start_btn_i};
      tape_prev_nxt  = tape_sel_i;
      addr_nxt       = addr_r;
      dir_nxt        = dir_r;
      bp_nxt         = bp_r;
      wt_nxt         = wt_r;
      go_nxt         = go_r;
      rep_nxt        = rep_r;
      iwr_nxt        = iwr_r;
      go_d_nxt       = go_r;
      step_cnt_nxt   = step_cnt_r;
      gojog_cnt_nxt  = gojog_cnt_r;
      rew_cnt_nxt    = rew_cnt_r;
      unl_cnt_nxt    = unl_cnt_r;

      // Direction: backspace only toggles, it never loads.
      if (backspace_i) begin
         if (timing_i.t2) begin
            dir_nxt = ~dir_r;
         end
      end else if (go_r && instr_i == INSTR_FORWARD) begin
         dir_nxt = 1'b1;
      end else if (go_r && instr_i == INSTR_REVERSE) begin
         dir_nxt = 1'b0;
      end

      // Program address counter wraps through all eight slots.
      if (bp_r && end_op && backspace_i) begin
         addr_nxt = '0;
      end else if ((!bp_r && end_op && !backspace_i) ||
                   (start_pulse && mode_i == MODE_LOAD)) begin
         addr_nxt = addr_r + 3'h1;
      end

      // Breakpoint: load holds it clear so loading never zeroes the address;
      // otherwise a match wins over a coinciding pulse 1 so no stop is lost.
      if (mode_i == MODE_LOAD) begin
         bp_nxt = 1'b0;
      end else if ((addr_r == bp_sel_i) && (end_op || start_pulse)) begin
         bp_nxt = 1'b1;
      end else if (timing_i.t1) begin
         bp_nxt = 1'b0;
      end

      // Write terminate: set wins over a coinciding busy pulse.
      if (timing_i.t3 && !dir_r && reply) begin
         wt_nxt = 1'b1;
      end else if (busy_pulse_i) begin
         wt_nxt = 1'b0;
      end

      // Simulated write reply for internal test.
      if (!int_test) begin
         iwr_nxt = 1'b0;
      end else if (go_pulse && dir_r && instr_i == INSTR_WRITE) begin
         iwr_nxt = 1'b1;
      end else if (go_pulse && !dir_r) begin
         iwr_nxt = 1'b0;
      end

      // Post-jog go one-shot starts when write terminate falls.
      if (wt_r && !wt_nxt) begin
         gojog_cnt_nxt = CNT_W'(PULSE_CYCLES);
      end else if (gojog_cnt_r != '0) begin
         gojog_cnt_nxt = gojog_cnt_r - 8'h1;
      end

      // Repeat flag; step mode drops it after one microsecond.
      if (start_pulse && mode_i != MODE_LOAD) begin
         rep_nxt = 1'b1;
         if (mode_i == MODE_STEP) begin
            step_cnt_nxt = CNT_W'(PULSE_CYCLES);
         end
      end else if (step_cnt_r != '0) begin
         step_cnt_nxt = step_cnt_r - 8'h1;
         if (step_cnt_r == 8'h1) begin
            rep_nxt = 1'b0;
         end
      end else if (mode_i == MODE_STEP) begin
         rep_nxt = 1'b0;
      end

      // Go flag: sets win over clears so a jog restart is not lost.
      if ((start_pulse && mode_i != MODE_LOAD) || gojog_cnt_r != '0 ||
          (rep_r && set_enable_i)) begin
         go_nxt = 1'b1;
      end else if (end_op || go_clear_i) begin
         go_nxt = 1'b0;
      end

      // Operator rewind and unload one-shots fire on selection.
      if (tape_sel_i == TAPE_REWIND && tape_prev_r != TAPE_REWIND) begin
         rew_cnt_nxt = CNT_W'(PULSE_CYCLES);
      end else if (rew_cnt_r != '0) begin
         rew_cnt_nxt = rew_cnt_r - 8'h1;
      end
      if (tape_sel_i == TAPE_UNLOAD && tape_prev_r != TAPE_UNLOAD) begin
         unl_cnt_nxt = CNT_W'(PULSE_CYCLES);
      end else if (unl_cnt_r != '0) begin
         unl_cnt_nxt = unl_cnt_r - 8'h1;
      end

      // Master clear overrides every flag except the simulated write reply, the go delay and the operator one-shots.
      if (master_clear) begin
         addr_nxt     = '0;
         dir_nxt      = 1'b0;
         bp_nxt       = 1'b0;
         wt_nxt       = 1'b0;
         go_nxt       = 1'b0;
         rep_nxt      = 1'b0;
         step_cnt_nxt = '0;
         gojog_cnt_nxt = '0;
      end
   end

   // Motion outputs; forward is a direction level, reverse, write and the rewind instruction wait for go, operator rewind does not.
   always_comb begin
      motion_nxt.fwd = wt_r | dir_r;
      motion_nxt.rev = go_r && instr_i == INSTR_REVERSE && !wt_r && !rew_cmd;
      motion_nxt.wr  = dir_r && instr_i == INSTR_WRITE && go_r &&
                       (write_ring_i || int_test || ss_test);
      motion_nxt.rew = rew_cmd || rew_cnt_r != '0;
      wr_reply_nxt   = reply;
      rew_n_nxt      = ~motion_nxt.rew;
      unl_n_nxt      = (unl_cnt_nxt == '0);
   end

   // Register stage for all state; outputs come straight from flops.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         ctrl_r       <= CTRL_RESET;
         prdata_r     <= 32'h0;
         pready_r     <= 1'b0;
         pslverr_r    <= 1'b0;
         start_sync_r <= 3'h0;
         tape_prev_r  <= TAPE_IDLE;
         addr_r       <= '0;
         dir_r        <= 1'b0;
         bp_r         <= 1'b0;
         wt_r         <= 1'b0;
         go_r         <= 1'b0;
         rep_r        <= 1'b0;
         iwr_r        <= 1'b0;
         go_d_r       <= 1'b0;
         step_cnt_r   <= '0;
         gojog_cnt_r  <= '0;
         rew_cnt_r    <= '0;
         unl_cnt_r    <= '0;
         motion_r     <= '0;
         wr_reply_r   <= 1'b0;
         rew_n_r      <= 1'b1;
         unl_n_r      <= 1'b1;
      end else begin
         ctrl_r       <= ctrl_nxt;
         prdata_r     <= prdata_nxt;
         pready_r     <= pready_nxt;
         pslverr_r    <= pslverr_nxt;
         start_sync_r <= start_sync_nxt;
         tape_prev_r  <= tape_prev_nxt;
         addr_r       <= addr_nxt;
         dir_r        <= dir_nxt;
         bp_r         <= bp_nxt;
         wt_r         <= wt_nxt;
         go_r         <= go_nxt;
         rep_r        <= rep_nxt;
         iwr_r        <= iwr_nxt;
         go_d_r       <= go_d_nxt;
         step_cnt_r   <= step_cnt_nxt;
         gojog_cnt_r  <= gojog_cnt_nxt;
         rew_cnt_r    <= rew_cnt_nxt;
         unl_cnt_r    <= unl_cnt_nxt;
         motion_r     <= motion_nxt;
         wr_reply_r   <= wr_reply_nxt;
         rew_n_r      <= rew_n_nxt;
         unl_n_r      <= unl_n_nxt;
      end
   end

   // Output drive; the two operator pulses are active low.
   assign prdata_o          = prdata_r;
   assign pready_o          = pready_r;
   assign pslverr_o         = pslverr_r;
   assign prog_addr_o       = addr_r;
   assign motion_o          = motion_r;
   assign go_o              = go_r;
   assign write_reply_o     = wr_reply_r;
   assign rewind_n_o        = rew_n_r;
   assign rewind_unload_n_o = unl_n_r;

endmodule : tape_seq

// File: sim/tape_seq_asserts.sv
`timescale 1ns/1ps
module tape_seq_checker
   import tape_seq_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
   input wire logic              ref_clk_i,
   input wire logic              rst_i,
   input wire logic              psel_i,
   input wire logic              penable_i,
   input wire logic              pwrite_i,
   input wire logic [31:0]       paddr_i,
   input wire logic [31:0]       pwdata_i,
   input wire logic [31:0]       prdata_o,
   input wire logic              pready_o,
   input wire logic              pslverr_o,
   input wire logic              start_btn_i,
   input wire mode_t             mode_i,
   input wire logic              write_reply_i,
   input wire logic [ADDR_W-1:0] prog_addr_o,
   input wire motion_t           motion_o,
   input wire logic              rewind_unload_n_o,
   input wire logic              go_o,
   input wire logic              write_reply_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   int unsigned lo_cnt_r;
   int unsigned lo_cnt_nxt;
   logic        itest_r;
   logic        itest_nxt;

   // Low time of the unload line is counted, since a long repetition would slow the tools.
   always_comb begin
      lo_cnt_nxt = rewind_unload_n_o ? 0 : lo_cnt_r + 1;
      itest_nxt  = itest_r;
      if (psel_i && !penable_i && pwrite_i && paddr_i == APB_OFS_CTRL) begin
         itest_nxt = pwdata_i[CTRL_IT_BIT];
      end
   end

   // Helper state follows the same synchronous reset as the block.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         lo_cnt_r <= 0;
         itest_r  <= 1'b0;
      end else begin
         lo_cnt_r <= lo_cnt_nxt;
         itest_r  <= itest_nxt;
      end
   end

   sequence setup_s;
      psel_i && !penable_i;
   endsequence
   sequence load_press_s;
      $rose(start_btn_i) && mode_i == MODE_LOAD;
   endsequence
   sequence unmapped_rd_s;
      setup_s ##0 (!pwrite_i && paddr_i != APB_OFS_CTRL && paddr_i != APB_OFS_STATUS);
   endsequence

   a_reset_clears_all: assert property ($fell(rst_i) |-> !go_o && prog_addr_o == 3'h0
      && motion_o == 4'h0 && rewind_unload_n_o && !pready_o) else $error("reset state wrong");
   a_apb_ready_next: assert property (setup_s |=> pready_o) else $error("pready late");
   a_apb_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr alone");
   a_apb_unmapped_err: assert property (unmapped_rd_s |=> pslverr_o && prdata_o == 32'h0)
      else $error("unmapped read not refused");
   a_write_needs_fwd: assert property (motion_o.wr |-> motion_o.fwd)
      else $error("write without forward");
   a_motion_needs_go: assert property (motion_o.wr || motion_o.rev |-> $past(go_o))
      else $error("motion without go");
   a_rev_not_rewind: assert property (motion_o.rev |-> !motion_o.rew)
      else $error("reverse with rewind");
   a_addr_steps_one: assert property ($changed(prog_addr_o) |->
      (prog_addr_o - $past(prog_addr_o)) == 3'h1 || prog_addr_o == 3'h0)
      else $error("address jump");
   a_load_advances: assert property (load_press_s |-> ##[1:6] $changed(prog_addr_o))
      else $error("load press did not advance");
   a_unload_width: assert property ($rose(rewind_unload_n_o) |-> lo_cnt_r == PULSE_CYCLES)
      else $error("unload pulse width wrong");
   a_reply_follows: assert property ((!itest_r && $stable(write_reply_i)) [*3]
      |-> write_reply_o == write_reply_i) else $error("write reply not from transport");
endmodule : tape_seq_checker

bind tape_seq tape_seq_checker #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.*);

// File: sim/tape_transport_model.sv
`timescale 1ns/1ps
module tape_transport_model
   import tape_seq_pkg::*;
#(
   parameter int unsigned TRAVEL = 40
) (
   input  wire logic    ref_clk_i,
   input  wire logic    rst_i,
   input  wire logic    slow_i,
   input  wire logic    ring_i,
   input  wire motion_t motion_i,
   input  wire logic    go_i,
   output logic         busy_pulse_o,
   output logic         load_point_o,
   output logic         end_of_tape_o,
   output logic         write_reply_o,
   output logic         write_ring_o
);
   logic [7:0] travel_r;
   logic [7:0] travel_nxt;
   logic [7:0] wait_r;
   logic [7:0] wait_nxt;
   logic       go_q_r;
   logic       reply_nxt;

   // Tape moves only while go is set and a direction is commanded, since the forward
   // line is a standing direction level; a slow transport takes longer to stop.
   always_comb begin
      travel_nxt = (go_i && (motion_i.fwd || motion_i.rev)) ?
                   travel_r + 8'(travel_r != 8'hff) : 8'h0;
      wait_nxt   = (wait_r != 8'h0) ? wait_r - 8'h1 : 8'h0;
      if (go_q_r && !go_i) begin
         wait_nxt = slow_i ? 8'h0c : 8'h02;
      end
      reply_nxt = (write_reply_o || motion_i.wr) && !motion_i.rew;
   end

   // Write current stays on after writing until a rewind, which is the harsh case.
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         travel_r      <= 8'h0;
         wait_r        <= 8'h0;
         go_q_r        <= 1'b0;
         write_reply_o <= 1'b0;
      end else begin
         travel_r      <= travel_nxt;
         wait_r        <= wait_nxt;
         go_q_r        <= go_i;
         write_reply_o <= reply_nxt;
      end
   end

   // Tape markers and the stop report are one-cycle pulses.
   assign end_of_tape_o = motion_i.fwd && travel_r == 8'(TRAVEL);
   assign load_point_o  = motion_i.rev && travel_r == 8'(TRAVEL);
   assign busy_pulse_o  = wait_r == 8'h01;
   assign write_ring_o  = ring_i;
endmodule : tape_transport_model

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import tape_seq_pkg::*;
   localparam int unsigned PULSE_TB = 4;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [31:0] paddr_i = 32'h0, pwdata_i = 32'h0, prdata_o, d;
   logic        pready_o, pslverr_o, e, start_btn_i = 1'b0, backspace_i = 1'b0;
   mode_t       mode_i = MODE_LOAD;
   tape_sel_t   tape_sel_i = TAPE_IDLE;
   logic [2:0]  bp_sel_i = 3'h7, prog_addr_o;
   instr_t      instr_i = INSTR_REWIND;
   timing_t     timing_i = '0;
   logic        record_mode_i = 1'b0, rec_end_i = 1'b0, go_clear_i = 1'b0, set_enable_i = 1'b0;
   logic        load_point_i, end_of_tape_i, busy_pulse_i, write_reply_i, write_ring_i;
   motion_t     motion_o;
   logic        rewind_n_o, rewind_unload_n_o, go_o, write_reply_o, slow = 1'b0, ring = 1'b1;
   int          errors = 0, comparisons = 0, n;
   instr_t      prog [8] = '{INSTR_FORWARD, INSTR_WRITE, INSTR_REVERSE, INSTR_REWIND,
                             INSTR_FORWARD, INSTR_FORWARD, INSTR_FORWARD, INSTR_FORWARD};

   tape_seq #(.PULSE_CYCLES(PULSE_TB)) uut (.*);
   tape_transport_model transport (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .slow_i(slow),
      .ring_i(ring), .motion_i(motion_o), .go_i(go_o), .busy_pulse_o(busy_pulse_i),
      .load_point_o(load_point_i), .end_of_tape_o(end_of_tape_i),
      .write_reply_o(write_reply_i), .write_ring_o(write_ring_i));

   // Clock and the stored program, which answers the current address like the memory.
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) instr_i <= prog[prog_addr_o];

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // One APB transfer; the request is held until pready is seen at an edge.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge ref_clk_i);
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= wd;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      @(posedge ref_clk_i);
      for (int i = 0; i < 20 && pready_o !== 1'b1; i++) @(posedge ref_clk_i);
      check("pready", 32'h1, {31'h0, pready_o});
      d = prdata_o;
      e = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic rd_chk(input string what, input logic [31:0] m, input logic [31:0] exp);
      apb(1'b0, APB_OFS_STATUS, 32'h0);
      check(what, exp, d & m);
   endtask : rd_chk

   task automatic press;
      start_btn_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      start_btn_i <= 1'b0;
      repeat (4) @(posedge ref_clk_i);
   endtask : press

   task automatic tick(input timing_t t);
      @(posedge ref_clk_i);
      timing_i <= t;
      @(posedge ref_clk_i);
      timing_i <= '0;
   endtask : tick

   // Master clear is a level, so it is raised and then dropped again.
   task automatic clear_all;
      apb(1'b1, APB_OFS_CTRL, 32'h1);
      apb(1'b1, APB_OFS_CTRL, 32'h0);
   endtask : clear_all

   task automatic print_verdict;
      if (errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : print_verdict

   // Watchdog sized well above the fewer than 1900 cycles the sequence can take.
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      errors++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      rd_chk("status", 32'h3fe, 32'h0);
      apb(1'b0, APB_OFS_CTRL, 32'h0);
      check("ctrl", CTRL_RESET, d);
      apb(1'b0, 32'h0000_0040, 32'h0);
      check("unmapped", 32'h1, {31'h0, e});
      repeat (3) press();
      check("load addr", 32'h3, {29'h0, prog_addr_o});
      check("load go", 32'h0, {31'h0, go_o});
      clear_all();
      check("clear addr", 32'h0, {29'h0, prog_addr_o});
      mode_i <= MODE_STEP;
      press();
      check("step go", 32'h1, {31'h0, go_o});
      check("step fwd", 32'h1, {31'h0, motion_o.fwd});
      rd_chk("step rep dir", 32'h14, 32'h04);
      for (int i = 0; i < 200 && prog_addr_o !== 3'h1; i++) @(posedge ref_clk_i);
      check("end op addr", 32'h1, {29'h0, prog_addr_o});
      repeat (20) @(posedge ref_clk_i);
      press();
      for (int i = 0; i < 20 && motion_o.wr !== 1'b1; i++) @(posedge ref_clk_i);
      check("write", 32'h1, {31'h0, motion_o.wr});
      for (int i = 0; i < 200 && prog_addr_o !== 3'h2; i++) @(posedge ref_clk_i);
      check("write end addr", 32'h2, {29'h0, prog_addr_o});
      repeat (20) @(posedge ref_clk_i);
      slow <= 1'b1;
      press();
      tick(timing_t'(3'h1));
      rd_chk("wterm set", 32'h44, 32'h40);
      check("jog", 32'h2, {30'h0, motion_o.fwd, motion_o.rev});
      for (int i = 0; i < 300 && motion_o.rew !== 1'b1; i++) @(posedge ref_clk_i);
      check("rewind", 32'h1, {31'h0, motion_o.rew});
      rd_chk("wterm end", 32'h48, 32'h08);
      clear_all();
      for (int k = 0; k < 2; k++) begin
         tape_sel_i <= (k == 0) ? TAPE_UNLOAD : TAPE_REWIND;
         n = 0;
         for (int i = 0; i < 20 && (k == 0 ? rewind_unload_n_o : rewind_n_o) !== 1'b0; i++)
            @(posedge ref_clk_i);
         while ((k == 0 ? rewind_unload_n_o : rewind_n_o) === 1'b0 && n < 50) begin
            n++;
            @(posedge ref_clk_i);
         end
         check("op pulse", PULSE_TB, n);
         tape_sel_i <= TAPE_IDLE;
         repeat (4) @(posedge ref_clk_i);
      end
      mode_i <= MODE_RUN;
      press();
      repeat (10) @(posedge ref_clk_i);
      rd_chk("run rep", 32'h10, 32'h10);
      mode_i <= MODE_STEP;
      rd_chk("rep cleared", 32'h10, 32'h0);
      repeat (60) @(posedge ref_clk_i);
      bp_sel_i <= 3'h1;
      press();
      rd_chk("bp set", 32'h20, 32'h20);
      repeat (80) @(posedge ref_clk_i);
      check("bp hold", 32'h1, {29'h0, prog_addr_o});
      tick(timing_t'(3'h4));
      rd_chk("bp clear", 32'h20, 32'h0);
      clear_all();
      backspace_i <= 1'b1;
      tick(timing_t'(3'h2));
      rd_chk("bs toggle", 32'h4, 32'h4);
      tick(timing_t'(3'h2));
      rd_chk("bs toggle back", 32'h4, 32'h0);
      // Internal test: the reply comes from the simulated flag, and write needs no ring.
      backspace_i <= 1'b0;
      ring        <= 1'b0;
      rd_chk("reply ext", 32'h2, 32'h2);
      apb(1'b1, APB_OFS_CTRL, 32'h2);
      rd_chk("reply int", 32'h2, 32'h0);
      press();
      for (int i = 0; i < 200 && prog_addr_o !== 3'h1; i++) @(posedge ref_clk_i);
      repeat (20) @(posedge ref_clk_i);
      press();
      check("int write", 32'h1, {31'h0, motion_o.wr});
      rd_chk("reply sim", 32'h2, 32'h2);
      print_verdict();
   end
endmodule : testbench
